// File: core/phy_irq_pkg.sv
package phy_irq_pkg;

  // register word offsets as printed (0x19 is not a multiple of four)
  localparam logic [7:0] MASK_INDEX = 8'h19;
  localparam logic [7:0] STATUS_INDEX = 8'h1A;
  localparam logic [7:0] MODE_INDEX = 8'h40;
  localparam logic [9:0] MASK_ADDR = {MASK_INDEX, 2'b00};
  localparam logic [9:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
  localparam logic [9:0] MODE_ADDR = {MODE_INDEX, 2'b00};

  // reset values
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [0:0] MODE_RESET = 1'h0;

  // field positions
  localparam int PIN_ENABLE_BIT = 15;
  localparam int PENDING_BIT = 15;
  localparam int SPEED_BIT = 14;
  localparam int LINK_BIT = 13;
  localparam int DUPLEX_BIT = 12;
  localparam int AN_ERROR_BIT = 11;
  localparam int AN_DONE_BIT = 10;
  localparam int PAGE_BIT = 9;
  localparam int SYMBOL_BIT = 8;
  localparam int LOCK_LOST_BIT = 7;
  localparam int CROSSOVER_BIT = 6;
  localparam int POLARITY_BIT = 5;
  localparam int JABBER_BIT = 4;
  localparam int FALSE_CARRIER_BIT = 3;
  localparam int PARALLEL_BIT = 2;
  localparam int MASTER_SLAVE_BIT = 1;
  localparam int RX_ERROR_BIT = 0;
  localparam int ENERGY_MODE_BIT = 0;

  // synchroniser depth for line events
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    SPEED_10 = 3'h1,
    SPEED_100 = 3'h2,
    SPEED_1000 = 3'h4
  } line_speed_t;

  // raw line events, one bit each, edge-detected by edge_sync after they enter
  typedef struct packed {
    logic speed_change;
    logic link_change;
    logic energy_seen;
    logic duplex_change;
    logic an_error;
    logic an_done;
    logic page_received;
    logic symbol_error;
    logic lock_lost;
    logic crossover_change;
    logic polarity_change;
    logic jabber;
    logic false_carrier;
    logic parallel_error;
    logic master_slave_error;
    logic rx_error;
  } line_events_t;

  // line mode qualifiers
  typedef struct packed {
    logic is_10;
    logic is_100;
    logic is_1000;
    logic an_enabled;
  } line_mode_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_WRITE = 3'h2,
    BUS_READ = 3'h4
  } bus_state_t;

endpackage

// File: core/edge_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-stage synchroniser plus rising-edge pulse, one per line event
module edge_sync #(
  parameter int WIDTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] pulse
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] pulse;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  // refused at elaboration: a zero-wide bank has nothing to synchronise
  if (WIDTH < 1)
  begin
    $error("edge_sync width must be positive");
  end

  // meta is read only by sync; edges are seen on sync vs last
  always_comb
  begin
    next_cur = cur;
    next_cur.meta = async_in;
    next_cur.sync = cur.meta;
    next_cur.last = cur.sync;
    next_cur.pulse = cur.sync & ~cur.last;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign pulse = cur.pulse;

endmodule
`default_nettype wire

// File: core/phy_interrupt_mask_status.sv
// Functional notes
// - pin-enable one lets the pending summary drive the interrupt pin
// - pin-enable zero: status bits still set, pin never asserted
// - interrupt pin low only when pin-enable and pending are both one
// - pending summary reads one while unacknowledged; cleared by status read
// - speed change sets status 14 only when mask 14; read clears
// - mask 13 gates energy-detect if mode bit set, else link change
// - mask 12 duplex, 11 negotiation error, 10 negotiation done
// - mask 9 page received, 8 symbol error, 7 lock lost
// - page, symbol, lock-lost, false-carrier only at 100 or 1000
// - mask 6 crossover change, only while auto-negotiation enabled
// - mask 5 polarity change, mask 4 jabber, jabber only at 10
// - jabber never raised at 100 or 1000
// - mask 3 false carrier, mask 2 parallel-detect error
// - mask 1 master/slave error, only at 1000
// - mask 0 enables receive-error event
// - status 13 from energy or link change per mode bit, mask needed
// - status bits 12 to 1 set only if mask bit set; read clears
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module phy_interrupt_mask_status #(
  parameter int EVENT_COUNT = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire phy_irq_pkg::line_events_t line_events,
  input wire phy_irq_pkg::line_mode_t line_mode,
  output logic mgmt_irq_out_n,
  output logic irq
);

  typedef struct packed {
    phy_irq_pkg::bus_state_t bus;
    logic [9:0] addr;
    logic [15:0] mask;
    logic [15:0] status;
    logic [0:0] mode;
    phy_irq_pkg::line_mode_t lmode;
    phy_irq_pkg::line_mode_t lmode_meta;
    logic [31:0] rdata;
    logic irq_n;
    logic irq;
  } blk_state_t;

  blk_state_t cur;
  blk_state_t next_cur;
  phy_irq_pkg::line_events_t ev;
  logic [15:0] raw;
  logic [15:0] qual;
  logic [15:0] hits;
  logic [15:0] held;
  logic take;
  logic status_read;

  // the status map and the event struct are fixed at sixteen sources
  if (EVENT_COUNT != 16)
  begin
    $error("event count must be 16");
  end

  // edge_sync holds exactly two stages ahead of its edge detector
  if (phy_irq_pkg::SYNC_STAGES != 2)
  begin
    $error("line synchroniser depth must be two");
  end

  // pins from the line pass two synchroniser flip-flops and a registered edge pulse before use
  edge_sync #(
    .WIDTH(16)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(line_events),
    .pulse(ev)
  );

  // map events to status positions; bit 15 carries no event
  always_comb
  begin
    raw = '0;
    raw[phy_irq_pkg::SPEED_BIT] = ev.speed_change;
    raw[phy_irq_pkg::LINK_BIT] = cur.mode[phy_irq_pkg::ENERGY_MODE_BIT] ?
                                 ev.energy_seen : ev.link_change;
    raw[phy_irq_pkg::DUPLEX_BIT] = ev.duplex_change;
    raw[phy_irq_pkg::AN_ERROR_BIT] = ev.an_error;
    raw[phy_irq_pkg::AN_DONE_BIT] = ev.an_done;
    raw[phy_irq_pkg::PAGE_BIT] = ev.page_received;
    raw[phy_irq_pkg::SYMBOL_BIT] = ev.symbol_error;
    raw[phy_irq_pkg::LOCK_LOST_BIT] = ev.lock_lost;
    raw[phy_irq_pkg::CROSSOVER_BIT] = ev.crossover_change;
    raw[phy_irq_pkg::POLARITY_BIT] = ev.polarity_change;
    raw[phy_irq_pkg::JABBER_BIT] = ev.jabber;
    raw[phy_irq_pkg::FALSE_CARRIER_BIT] = ev.false_carrier;
    raw[phy_irq_pkg::PARALLEL_BIT] = ev.parallel_error;
    raw[phy_irq_pkg::MASTER_SLAVE_BIT] = ev.master_slave_error;
    raw[phy_irq_pkg::RX_ERROR_BIT] = ev.rx_error;
  end

  // mode qualifiers: sources that mean nothing in the current mode are dropped
  always_comb
  begin
    qual = 16'hFFFF;
    qual[phy_irq_pkg::PAGE_BIT] = cur.lmode.is_100 | cur.lmode.is_1000;
    qual[phy_irq_pkg::SYMBOL_BIT] = cur.lmode.is_100 | cur.lmode.is_1000;
    qual[phy_irq_pkg::LOCK_LOST_BIT] = cur.lmode.is_100 | cur.lmode.is_1000;
    qual[phy_irq_pkg::FALSE_CARRIER_BIT] = cur.lmode.is_100 | cur.lmode.is_1000;
    qual[phy_irq_pkg::CROSSOVER_BIT] = cur.lmode.an_enabled;
    qual[phy_irq_pkg::JABBER_BIT] = cur.lmode.is_10;
    qual[phy_irq_pkg::MASTER_SLAVE_BIT] = cur.lmode.is_1000;
    qual[phy_irq_pkg::PENDING_BIT] = 1'b0;
  end

  // each source is gated by its own mask bit
  assign hits = raw & qual & cur.mask;

  // a status read is the data phase of a read of the status word
  assign status_read = (cur.bus == phy_irq_pkg::BUS_READ) &&
                       (cur.addr == phy_irq_pkg::STATUS_ADDR);
  assign take = hsel && hready && htrans[1];

  // bits cleared by a read, but an event in the same cycle survives
  assign held = status_read ? 16'h0000 : cur.status;

  // bus slave, register file and interrupt pin
  always_comb
  begin
    next_cur = cur;
    next_cur.lmode_meta = line_mode;
    next_cur.lmode = cur.lmode_meta;
    next_cur.status[14:0] = held[14:0] | hits[14:0];
    next_cur.status[phy_irq_pkg::PENDING_BIT] =
      (held[phy_irq_pkg::PENDING_BIT] | (|hits[14:0]));
    next_cur.rdata = cur.rdata;
    case (cur.bus)
      phy_irq_pkg::BUS_IDLE:
      begin
        next_cur.bus = phy_irq_pkg::BUS_IDLE;
      end
      phy_irq_pkg::BUS_WRITE:
      begin
        next_cur.bus = phy_irq_pkg::BUS_IDLE;
        if (cur.addr == phy_irq_pkg::MASK_ADDR)
        begin
          next_cur.mask = hwdata[15:0];
        end
        else if (cur.addr == phy_irq_pkg::MODE_ADDR)
        begin
          next_cur.mode = hwdata[0:0];
        end
      end
      phy_irq_pkg::BUS_READ:
      begin
        next_cur.bus = phy_irq_pkg::BUS_IDLE;
      end
      default:
      begin
        next_cur.bus = phy_irq_pkg::BUS_IDLE;
      end
    endcase
    if (take)
    begin
      next_cur.addr = haddr[9:0];
      next_cur.bus = hwrite ? phy_irq_pkg::BUS_WRITE : phy_irq_pkg::BUS_READ;
      // read data captured at address phase; status reads its live value
      if (!hwrite)
      begin
        if (haddr[9:0] == phy_irq_pkg::MASK_ADDR)
        begin
          next_cur.rdata = {16'h0000, next_cur.mask};
        end
        else if (haddr[9:0] == phy_irq_pkg::STATUS_ADDR)
        begin
          next_cur.rdata = {16'h0000, next_cur.status};
        end
        else if (haddr[9:0] == phy_irq_pkg::MODE_ADDR)
        begin
          next_cur.rdata = {31'h00000000, next_cur.mode};
        end
        else
        begin
          next_cur.rdata = 32'h00000000;
        end
      end
    end
    // pin is NAND of pin-enable and pending summary
    next_cur.irq_n = ~(next_cur.mask[phy_irq_pkg::PIN_ENABLE_BIT] &
                       next_cur.status[phy_irq_pkg::PENDING_BIT]);
    next_cur.irq = |(next_cur.status[14:0] & next_cur.mask[14:0]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cur.bus <= phy_irq_pkg::BUS_IDLE;
      cur.addr <= 10'h000;
      cur.mask <= phy_irq_pkg::MASK_RESET;
      cur.status <= phy_irq_pkg::STATUS_RESET;
      cur.mode <= phy_irq_pkg::MODE_RESET;
      cur.lmode <= '0;
      cur.lmode_meta <= '0;
      cur.rdata <= 32'h00000000;
      cur.irq_n <= 1'b1;
      cur.irq <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign hrdata = cur.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mgmt_irq_out_n = cur.irq_n;
  assign irq = cur.irq;

  // pin low exactly when enable and pending both one
  chk_pin_nand: assert property (@(posedge hclk) disable iff (!hresetn)
    !mgmt_irq_out_n == (cur.mask[15] && cur.status[15]))
    else $error("interrupt pin disagrees with enable and pending");
  chk_pin_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    !cur.mask[15] |-> mgmt_irq_out_n)
    else $error("pin asserted while pin-enable clear");
  chk_pin_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.mask[15] && cur.status[15]) |-> !mgmt_irq_out_n)
    else $error("pin not asserted with pending and enable");

  // status keeps collecting while the pin is disabled
  chk_quiet_pin_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cur.mask[15] && ev.speed_change && cur.mask[14]) |=> cur.status[15])
    else $error("summary not set with pin disabled");

  // summary tracks the individual bits and drops only on a read
  chk_read_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (status_read && hits == 16'h0000) |=> cur.status == 16'h0000)
    else $error("status not cleared by read");
  chk_summary_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (|hits) |=> cur.status[15])
    else $error("summary not set on event");
  chk_summary_match: assert property (@(posedge hclk) disable iff (!hresetn)
    cur.status[15] == (|cur.status[14:0]))
    else $error("summary disagrees with individual bits");
  chk_pending_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (!status_read && cur.status[15]) |=> cur.status[15])
    else $error("summary dropped without a read");

  // writes land at the end of the data phase; status takes none
  chk_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.bus == phy_irq_pkg::BUS_WRITE && cur.addr == phy_irq_pkg::MASK_ADDR) |=>
    cur.mask == $past(hwdata[15:0]))
    else $error("mask write lost");
  chk_mode_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.bus == phy_irq_pkg::BUS_WRITE && cur.addr == phy_irq_pkg::MODE_ADDR) |=>
    cur.mode[0] == $past(hwdata[0]))
    else $error("mode write lost");
  chk_status_no_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.bus == phy_irq_pkg::BUS_WRITE && cur.addr == phy_irq_pkg::STATUS_ADDR &&
    hits == 16'h0000 && cur.status == 16'h0000) |=> cur.status == 16'h0000)
    else $error("status changed by a write");

  // speed and link or energy sources
  chk_speed_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.speed_change && cur.mask[14]) |=> cur.status[14] && cur.status[15])
    else $error("speed event lost");
  chk_masked_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (!status_read && !cur.mask[14] && !cur.status[14]) |=> !cur.status[14])
    else $error("masked speed bit set");
  chk_speed_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    (!status_read && cur.status[14]) |=> cur.status[14])
    else $error("speed bit dropped without a read");
  chk_link_source: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.mode[0] && ev.energy_seen && cur.mask[13]) |=> cur.status[13])
    else $error("energy event lost");
  chk_link_change: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cur.mode[0] && ev.link_change && cur.mask[13]) |=> cur.status[13])
    else $error("link change event lost");
  chk_link_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (cur.mode[0] && !ev.energy_seen && !status_read && !cur.status[13]) |=> !cur.status[13])
    else $error("link change leaked while energy selected");

  // sources that apply in every mode
  chk_duplex_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.duplex_change && cur.mask[12]) |=> cur.status[12])
    else $error("duplex event lost");
  chk_an_error_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.an_error && cur.mask[11]) |=> cur.status[11])
    else $error("negotiation error event lost");
  chk_an_done_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.an_done && cur.mask[10]) |=> cur.status[10])
    else $error("negotiation done event lost");
  chk_polarity_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.polarity_change && cur.mask[5]) |=> cur.status[5])
    else $error("polarity event lost");
  chk_parallel_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.parallel_error && cur.mask[2]) |=> cur.status[2])
    else $error("parallel-detect event lost");
  chk_rx_error_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.rx_error && cur.mask[0]) |=> cur.status[0])
    else $error("receive error event lost");

  // sources that depend on speed or negotiation
  chk_page_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.page_received && cur.mask[9] && (cur.lmode.is_100 || cur.lmode.is_1000)) |=>
    cur.status[9])
    else $error("page event lost");
  chk_symbol_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.symbol_error && cur.mask[8] && (cur.lmode.is_100 || cur.lmode.is_1000)) |=>
    cur.status[8])
    else $error("symbol error event lost");
  chk_lock_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.lock_lost && cur.mask[7] && (cur.lmode.is_100 || cur.lmode.is_1000)) |=>
    cur.status[7])
    else $error("lock-lost event lost");
  chk_carrier_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.false_carrier && cur.mask[3] && (cur.lmode.is_100 || cur.lmode.is_1000)) |=>
    cur.status[3])
    else $error("false carrier event lost");
  chk_slow_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cur.lmode.is_100 && !cur.lmode.is_1000 && !status_read &&
    (cur.status & 16'h0388) == 16'h0000) |=> (cur.status & 16'h0388) == 16'h0000)
    else $error("fast-only source raised at 10 Mb/s");
  chk_crossover_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.crossover_change && cur.mask[6] && cur.lmode.an_enabled) |=> cur.status[6])
    else $error("crossover event lost");
  chk_crossover_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cur.lmode.an_enabled && !status_read && !cur.status[6]) |=> !cur.status[6])
    else $error("crossover raised without negotiation");
  chk_jabber_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.jabber && cur.mask[4] && cur.lmode.is_10) |=> cur.status[4])
    else $error("jabber event lost");
  chk_jabber_fast: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cur.lmode.is_10 && !status_read && !cur.status[4]) |=> !cur.status[4])
    else $error("jabber raised outside 10 Mb/s");
  chk_ms_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (ev.master_slave_error && cur.mask[1] && cur.lmode.is_1000) |=> cur.status[1])
    else $error("master/slave event lost");
  chk_ms_only_gig: assert property (@(posedge hclk) disable iff (!hresetn)
    (!cur.lmode.is_1000 && !status_read && !cur.status[1]) |=> !cur.status[1])
    else $error("master/slave raised outside 1000 Mb/s");

  // with no mask bits in 12..1 nothing there can ever set
  chk_unmasked_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (!status_read && cur.mask[12:1] == 12'h000 && cur.status[12:1] == 12'h000) |=>
    cur.status[12:1] == 12'h000)
    else $error("status set without its mask bit");

endmodule
`default_nettype wire

// File: verification/test_phy_interrupt_mask_status.sv
`timescale 1ns/1ns
`default_nettype none
module test_phy_interrupt_mask_status;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic mgmt_irq_out_n;
  logic irq;
  phy_irq_pkg::line_events_t line_events = '0;
  phy_irq_pkg::line_mode_t line_mode = '0;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic [15:0] masks [4] = '{16'hFFFF, 16'h7FFF, 16'hD555, 16'h2AAA};
  logic [3:0] modes [4] = '{4'h9, 4'h5, 4'h3, 4'h2};

  // single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // 250 MHz
  always #2 hclk = ~hclk;

  phy_interrupt_mask_status #(.EVENT_COUNT(16)) phy_interrupt_mask_status_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .line_events(line_events),
    .line_mode(line_mode),
    .mgmt_irq_out_n(mgmt_irq_out_n),
    .irq(irq)
  );

  task automatic stop_test();
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single-word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // status the line events should leave behind, mode order is 10,100,1000,an
  function automatic logic [15:0] expect_status(logic [15:0] ev, logic [3:0] md, logic sel,
    logic [15:0] m);
    logic [15:0] s;
    s = {1'b0, ev[15], sel ? ev[13] : ev[14], ev[12:0]};
    if (!(md[2] | md[1])) s = s & ~16'h0388;
    if (!md[0]) s[6] = 1'b0;
    if (!md[3]) s[4] = 1'b0;
    if (!md[1]) s[1] = 1'b0;
    s = s & m & 16'h7FFF;
    s[15] = |s[14:0];
    return s;
  endfunction

  // pulse a set of events, then look at pin, level, status and its clear on read
  task automatic run_case(input logic [15:0] m, input logic [3:0] md, input logic sel,
    input logic [15:0] ev);
    logic [15:0] e;
    e = expect_status(ev, md, sel, m);
    xfer(1'b1, phy_irq_pkg::MODE_ADDR, {31'h0, sel});
    xfer(1'b1, phy_irq_pkg::MASK_ADDR, {16'h0, m});
    line_mode <= md;
    tick(4);
    line_events <= ev;
    tick(8);
    line_events <= '0;
    tick(6);
    check({31'h0, mgmt_irq_out_n}, {31'h0, ~(m[15] & e[15])});
    check({31'h0, irq}, {31'h0, e[15]});
    rd_chk(phy_irq_pkg::STATUS_ADDR, {16'h0, e});
    rd_chk(phy_irq_pkg::STATUS_ADDR, 32'h0);
    tick(2);
    check({31'h0, mgmt_irq_out_n}, 32'h1);
  endtask

  // main sequence
  initial
  begin
    tick(16);
    hresetn <= 1'b1;
    tick(1);
    rd_chk(phy_irq_pkg::MASK_ADDR, 32'h0);
    rd_chk(phy_irq_pkg::STATUS_ADDR, 32'h0);
    check({31'h0, mgmt_irq_out_n}, 32'h1);
    // access kinds: upper bits read zero, status is read-only, holes read zero
    xfer(1'b1, phy_irq_pkg::MASK_ADDR, 32'hFFFFFFFF);
    rd_chk(phy_irq_pkg::MASK_ADDR, 32'h0000FFFF);
    xfer(1'b1, phy_irq_pkg::STATUS_ADDR, 32'h0000FFFF);
    rd_chk(phy_irq_pkg::STATUS_ADDR, 32'h0);
    rd_chk(10'h200, 32'h0);
    xfer(1'b1, phy_irq_pkg::MODE_ADDR, 32'h1);
    rd_chk(phy_irq_pkg::MODE_ADDR, 32'h1);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    // all-events patterns without energy, then without link, under both selector settings
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 4; k++)
        for (int j = 0; j < 4; j++)
        begin
          run_case(masks[k], modes[j], s[0], 16'hDFFF);
          run_case(masks[k], modes[j], s[0], 16'hBFFF);
        end
    // reset in mid-run must bring the mask back to zero
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    rd_chk(phy_irq_pkg::MASK_ADDR, 32'h0);
    check({31'h0, mgmt_irq_out_n}, 32'h1);
    stop_test();
  end

  // about 1830 cycles are needed, so this only trips on a hang
  initial
  begin
    tick(20000);
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
